// File: hdl/lcr_pattern_track.sv
`timescale 1ns/100ps
module lcr_pattern_track
  import lcr_pkg::*;
#(
  parameter int unsigned REP_W = LCR_REP_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire logic arm_in,
  input wire logic cycle_done_in,
  input wire logic [REP_W-1:0] repeat_in,
  output logic running_out
);

  lcr_seq_state_e state_q;
  lcr_seq_state_e state_d;
  logic [REP_W-1:0] count_q;
  logic last_cycle;

  // a repeat value of zero means the pattern never stops on its own
  assign last_cycle = (repeat_in != '0) && (REP_W'(count_q + 1'b1) == repeat_in);

  always_comb begin
    state_d = state_q;
    unique case (state_q)
      LCR_SEQ_IDLE: begin
        if (arm_in) begin
          state_d = LCR_SEQ_RUN;
        end
      end
      LCR_SEQ_RUN: begin
        if (!arm_in) begin
          state_d = LCR_SEQ_IDLE;
        end else if (cycle_done_in && last_cycle) begin
          state_d = LCR_SEQ_DONE;
        end
      end
      LCR_SEQ_DONE: begin
        // stays stopped until the channel is disarmed and armed again
        if (!arm_in) begin
          state_d = LCR_SEQ_IDLE;
        end
      end
      default: state_d = LCR_SEQ_IDLE;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      state_q <= LCR_SEQ_IDLE;
    end else begin
      state_q <= state_d;
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in || state_q != LCR_SEQ_RUN) begin
      count_q <= '0;
    end else if (cycle_done_in && !last_cycle) begin
      count_q <= REP_W'(count_q + 1'b1);
    end
  end

  assign running_out = (state_q == LCR_SEQ_RUN);

  property p_stop_on_disarm;
    @(posedge clk_in) disable iff (rst_in)
    (running_out && !arm_in) |=> !running_out;
  endproperty
  a_stop_on_disarm: assert property (p_stop_on_disarm) else $error("pattern kept running after disarm");

  property p_stop_on_count;
    @(posedge clk_in) disable iff (rst_in)
    (running_out && arm_in && cycle_done_in && last_cycle) |=> !running_out ##1 (!running_out || !$past(arm_in));
  endproperty
  a_stop_on_count: assert property (p_stop_on_count) else $error("pattern kept running after last repeat");

endmodule // lcr_pattern_track

// File: hdl/lcr_pkg.sv
package lcr_pkg;

  localparam int unsigned LCR_NUM_CH = 3;
  localparam int unsigned LCR_ADDR_W = 8;
  localparam int unsigned LCR_DATA_W = 8;
  localparam int unsigned LCR_CUR_W = 4;
  localparam int unsigned LCR_REP_W = 4;

  // register offsets on the serial register port
  localparam logic [7:0] LCR_OFS_CHIP_CTRL = 8'h01;
  localparam logic [7:0] LCR_OFS_EVT_STATUS = 8'h02;
  localparam logic [7:0] LCR_OFS_PAT_STATUS = 8'h03;
  localparam logic [7:0] LCR_OFS_PROT = 8'h04;
  localparam logic [7:0] LCR_OFS_LED_CTRL = 8'h30;
  localparam logic [7:0] LCR_OFS_CH0_CFG = 8'h31;
  localparam logic [7:0] LCR_OFS_CH1_CFG = 8'h32;
  localparam logic [7:0] LCR_OFS_CH2_CFG = 8'h33;

  // reset values
  localparam logic [7:0] LCR_RST_CHIP_CTRL = 8'h00;
  localparam logic [7:0] LCR_RST_PROT = 8'h00;
  localparam logic [7:0] LCR_RST_LED_CTRL = 8'h00;
  localparam logic [7:0] LCR_RST_CH_CFG = 8'h00;

  // writable bits; everything else is stored as zero and reads as zero
  localparam logic [7:0] LCR_WMASK_CHIP_CTRL = 8'h01;
  localparam logic [7:0] LCR_WMASK_PROT = 8'hff;
  localparam logic [7:0] LCR_WMASK_LED_CTRL = 8'h2f;
  localparam logic [7:0] LCR_WMASK_CH0_CFG = 8'hff;
  localparam logic [7:0] LCR_WMASK_CHN_CFG = 8'h7f;

  // field positions
  localparam int unsigned LCR_BIT_CHIP_EN = 0;
  localparam int unsigned LCR_BIT_UV_FLAG = 3;
  localparam int unsigned LCR_BIT_OT_FLAG = 2;
  localparam int unsigned LCR_BIT_UV_PROT_OFF = 7;
  localparam int unsigned LCR_BIT_OT_PROT_OFF = 6;
  localparam int unsigned LCR_BIT_UV_DET_OFF = 5;
  localparam int unsigned LCR_BIT_OT_DET_OFF = 4;
  localparam int unsigned LCR_LSB_UV_TH = 2;
  localparam int unsigned LCR_LSB_IMAX = 0;
  localparam int unsigned LCR_BIT_CARRIER = 5;
  localparam int unsigned LCR_BIT_LED_RSVD = 4;
  localparam int unsigned LCR_BIT_CURVE = 3;
  localparam int unsigned LCR_LSB_LED_EN = 0;
  localparam int unsigned LCR_BIT_SYNC = 7;
  localparam int unsigned LCR_BIT_FADE_OUT = 6;
  localparam int unsigned LCR_BIT_FADE_IN = 5;
  localparam int unsigned LCR_BIT_PAT_MODE = 4;
  localparam int unsigned LCR_LSB_CUR = 0;

  // carrier in Hz, threshold in units of 10 mV, current in mA
  localparam logic [7:0] LCR_CARRIER_HZ_0 = 8'hfa;
  localparam logic [7:0] LCR_CARRIER_HZ_1 = 8'h7d;
  localparam logic [7:0] LCR_UV_TH_BASE = 8'hc8;
  localparam logic [7:0] LCR_UV_TH_STEP = 8'h0a;
  localparam logic [4:0] LCR_IMAX_MA_00 = 5'h0f;
  localparam logic [4:0] LCR_IMAX_MA_01 = 5'h1e;
  localparam logic [4:0] LCR_IMAX_MA_10 = 5'h05;
  localparam logic [4:0] LCR_IMAX_MA_11 = 5'h0a;
  localparam logic [3:0] LCR_CUR_FULL_SCALE = 4'hf;

  typedef struct packed {
    logic wr;
    logic rd;
    logic [7:0] addr;
    logic [7:0] wdata;
  } lcr_reg_req_s;

  typedef struct packed {
    logic output_enable;
    logic pattern_mode;
    logic fade_in;
    logic fade_out;
    logic pwm_from_ch0;
    logic [3:0] current_scale;
    logic [8:0] current_x15;
  } lcr_chan_s;

  typedef enum logic [2:0] {
    LCR_SEQ_IDLE = 3'b001,
    LCR_SEQ_RUN = 3'b010,
    LCR_SEQ_DONE = 3'b100
  } lcr_seq_state_e;

  function automatic logic [7:0] lcr_masked(input logic [7:0] data, input logic [7:0] mask);
    return data & mask;
  endfunction

  function automatic logic [4:0] lcr_imax_ma(input logic [1:0] code);
    case (code)
      2'b00: return LCR_IMAX_MA_00;
      2'b01: return LCR_IMAX_MA_01;
      2'b10: return LCR_IMAX_MA_10;
      default: return LCR_IMAX_MA_11;
    endcase
  endfunction

  // channel current times the full-scale divisor, so that current = value / 15 mA
  function automatic logic [8:0] lcr_current_x15(input logic [1:0] code, input logic [3:0] scale);
    return 9'({4'h0, lcr_imax_ma(code)} * {5'h00, scale});
  endfunction

  function automatic logic [7:0] lcr_uv_th_10mv(input logic [1:0] code);
    return 8'(LCR_UV_TH_BASE + LCR_UV_TH_STEP * {6'h00, code});
  endfunction

endpackage

// File: hdl/lcr_regs.sv
`timescale 1ns/100ps
// How it works
// - read-only pattern status: bits 2..0 show channels running, upper bits zero, resets zero
// - overtemp flag high clears chip enable unless overtemp protection is turned off
// - detect-off bits stop undervolt or overtemp flags from setting; default is detecting
// - two-bit threshold code picks 2.0, 2.1, 2.2 or 2.3 volts
// - two-bit max current code picks 15, 30, 5 or 10 mA
// - carrier bit picks 250 Hz when clear and 125 Hz when set
// - curve bit picks exponential transitions when clear and linear when set
// - three enable bits switch each channel output on when set and chip enable is set
// - channel 0 sync bit picks individual or synchronous control of all channels
// - fade-out bit ramps PWM decreases over fall time, manual mode only
// - fade-in bit ramps PWM increases over rise time, manual mode only
// - mode bit picks manual mode when clear and pattern mode when set
// - channel current is max current times scale over fifteen at full PWM
// - chip enable clear means standby, set means active; protection clears it
// - reading the event status register clears the undervolt and overtemp flags
// - sync mode: channels 1,2 follow channel 0 PWM and mode bits, keep own current
module lcr_regs
  import lcr_pkg::*;
#(
  parameter int unsigned NUM_CH = LCR_NUM_CH,
  parameter int unsigned REP_W = LCR_REP_W
) (
  input wire logic clk_in,
  input wire logic rst_in,
  input wire lcr_reg_req_s reg_req_in,
  output logic [LCR_DATA_W-1:0] reg_rdata_out,
  output logic reg_rdata_valid_out,
  input wire logic undervolt_detect_in,
  input wire logic overtemp_detect_in,
  input wire logic [NUM_CH-1:0] pattern_cycle_done_in,
  input wire logic [NUM_CH-1:0][REP_W-1:0] pattern_repeat_in,
  output logic chip_active_enable_out,
  output logic undervolt_detect_enable_out,
  output logic overtemp_detect_enable_out,
  output logic [7:0] undervolt_threshold_10mv_out,
  output logic [4:0] max_current_ma_out,
  output logic [7:0] carrier_hz_out,
  output logic transition_curve_linear_out,
  output logic sync_mode_out,
  output lcr_chan_s [NUM_CH-1:0] chan_out
);

  logic [7:0] chip_ctrl_q;
  logic [7:0] prot_q;
  logic [7:0] led_ctrl_q;
  logic [7:0] ch_cfg_q [NUM_CH];
  logic uv_meta_q;
  logic uv_sync_q;
  logic ot_meta_q;
  logic ot_sync_q;
  logic undervolt_status_flag_q;
  logic overtemp_status_flag_q;
  logic uv_flag_prev_q;
  logic [NUM_CH-1:0] pattern_running;
  logic [7:0] rdata_d;
  logic wr_chip;
  logic wr_prot;
  logic wr_led;
  logic [NUM_CH-1:0] wr_cfg;
  logic status_read;
  logic uv_set;
  logic ot_set;
  logic uv_trip;
  logic ot_trip;
  logic undervolt_protect_off;
  logic overtemp_protect_off;
  logic undervolt_detect_off;
  logic overtemp_detect_off;
  logic [1:0] undervolt_threshold;
  logic [1:0] max_current_code;
  logic carrier_select_a;
  logic transition_curve_select;
  logic sync_sel;
  logic [NUM_CH-1:0] chx_output_enable;
  logic [NUM_CH-1:0] eff_mode;
  logic [NUM_CH-1:0] eff_fade_in;
  logic [NUM_CH-1:0] eff_fade_out;
  logic [NUM_CH-1:0] pattern_arm;
  lcr_chan_s [NUM_CH-1:0] chan_d;

  assign wr_chip = reg_req_in.wr && (reg_req_in.addr == LCR_OFS_CHIP_CTRL);
  assign wr_prot = reg_req_in.wr && (reg_req_in.addr == LCR_OFS_PROT);
  assign wr_led = reg_req_in.wr && (reg_req_in.addr == LCR_OFS_LED_CTRL);
  assign wr_cfg[0] = reg_req_in.wr && (reg_req_in.addr == LCR_OFS_CH0_CFG);
  assign wr_cfg[1] = reg_req_in.wr && (reg_req_in.addr == LCR_OFS_CH1_CFG);
  assign wr_cfg[2] = reg_req_in.wr && (reg_req_in.addr == LCR_OFS_CH2_CFG);
  assign status_read = reg_req_in.rd && (reg_req_in.addr == LCR_OFS_EVT_STATUS);

  assign undervolt_protect_off = prot_q[LCR_BIT_UV_PROT_OFF];
  assign overtemp_protect_off = prot_q[LCR_BIT_OT_PROT_OFF];
  assign undervolt_detect_off = prot_q[LCR_BIT_UV_DET_OFF];
  assign overtemp_detect_off = prot_q[LCR_BIT_OT_DET_OFF];
  assign undervolt_threshold = prot_q[LCR_LSB_UV_TH +: 2];
  assign max_current_code = prot_q[LCR_LSB_IMAX +: 2];
  assign carrier_select_a = led_ctrl_q[LCR_BIT_CARRIER];
  assign transition_curve_select = led_ctrl_q[LCR_BIT_CURVE];
  assign chx_output_enable = led_ctrl_q[LCR_LSB_LED_EN +: NUM_CH];
  assign sync_sel = ch_cfg_q[0][LCR_BIT_SYNC];

  // the detectors are analog comparators, asynchronous to this clock
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      uv_meta_q <= 1'b0;
      uv_sync_q <= 1'b0;
      ot_meta_q <= 1'b0;
      ot_sync_q <= 1'b0;
    end else begin
      uv_meta_q <= undervolt_detect_in;
      uv_sync_q <= uv_meta_q;
      ot_meta_q <= overtemp_detect_in;
      ot_sync_q <= ot_meta_q;
    end
  end

  assign uv_set = uv_sync_q && !undervolt_detect_off;
  assign ot_set = ot_sync_q && !overtemp_detect_off;

  // a detection arriving with the clearing read survives it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      undervolt_status_flag_q <= 1'b0;
      overtemp_status_flag_q <= 1'b0;
      uv_flag_prev_q <= 1'b0;
    end else begin
      undervolt_status_flag_q <= uv_set || (undervolt_status_flag_q && !status_read);
      overtemp_status_flag_q <= ot_set || (overtemp_status_flag_q && !status_read);
      uv_flag_prev_q <= undervolt_status_flag_q;
    end
  end

  assign uv_trip = undervolt_status_flag_q && !uv_flag_prev_q && !undervolt_protect_off;
  assign ot_trip = overtemp_status_flag_q && !overtemp_protect_off;

  // protection beats a host write that would turn the chip on in the same cycle
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chip_ctrl_q <= LCR_RST_CHIP_CTRL;
    end else if (uv_trip || ot_trip) begin
      chip_ctrl_q[LCR_BIT_CHIP_EN] <= 1'b0;
    end else if (wr_chip) begin
      chip_ctrl_q <= lcr_masked(reg_req_in.wdata, LCR_WMASK_CHIP_CTRL);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      prot_q <= LCR_RST_PROT;
    end else if (wr_prot) begin
      prot_q <= lcr_masked(reg_req_in.wdata, LCR_WMASK_PROT);
    end
  end

  // the reserved bit is dropped so a careless write cannot reach it
  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      led_ctrl_q <= LCR_RST_LED_CTRL;
    end else if (wr_led) begin
      led_ctrl_q <= lcr_masked(reg_req_in.wdata, LCR_WMASK_LED_CTRL);
    end
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      for (int i = 0; i < NUM_CH; i++) begin
        ch_cfg_q[i] <= LCR_RST_CH_CFG;
      end
    end else begin
      for (int i = 0; i < NUM_CH; i++) begin
        if (wr_cfg[i]) begin
          ch_cfg_q[i] <= lcr_masked(reg_req_in.wdata, (i == 0) ? LCR_WMASK_CH0_CFG : LCR_WMASK_CHN_CFG);
        end
      end
    end
  end

  // in sync mode channel 0 mode and fade bits stand for every channel
  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      eff_mode[i] = sync_sel ? ch_cfg_q[0][LCR_BIT_PAT_MODE] : ch_cfg_q[i][LCR_BIT_PAT_MODE];
      eff_fade_in[i] = (sync_sel ? ch_cfg_q[0][LCR_BIT_FADE_IN] : ch_cfg_q[i][LCR_BIT_FADE_IN]) && !eff_mode[i];
      eff_fade_out[i] = (sync_sel ? ch_cfg_q[0][LCR_BIT_FADE_OUT] : ch_cfg_q[i][LCR_BIT_FADE_OUT]) && !eff_mode[i];
      pattern_arm[i] = chip_ctrl_q[LCR_BIT_CHIP_EN] && chx_output_enable[i] && eff_mode[i];
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_CH; i++) begin
      chan_d[i].output_enable = chx_output_enable[i] && chip_ctrl_q[LCR_BIT_CHIP_EN];
      chan_d[i].pattern_mode = eff_mode[i];
      chan_d[i].fade_in = eff_fade_in[i];
      chan_d[i].fade_out = eff_fade_out[i];
      chan_d[i].pwm_from_ch0 = sync_sel && (i != 0);
      chan_d[i].current_scale = ch_cfg_q[i][LCR_LSB_CUR +: LCR_CUR_W];
      chan_d[i].current_x15 = lcr_current_x15(max_current_code, ch_cfg_q[i][LCR_LSB_CUR +: LCR_CUR_W]);
    end
  end

  for (genvar g = 0; g < NUM_CH; g++) begin : g_track
    lcr_pattern_track #(
      .REP_W(REP_W)
    ) u_track (
      .clk_in(clk_in),
      .rst_in(rst_in),
      .arm_in(pattern_arm[g]),
      .cycle_done_in(pattern_cycle_done_in[g]),
      .repeat_in(pattern_repeat_in[g]),
      .running_out(pattern_running[g])
    );
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      chip_active_enable_out <= 1'b0;
      undervolt_detect_enable_out <= 1'b0;
      overtemp_detect_enable_out <= 1'b0;
      undervolt_threshold_10mv_out <= LCR_UV_TH_BASE;
      max_current_ma_out <= LCR_IMAX_MA_00;
      carrier_hz_out <= LCR_CARRIER_HZ_0;
      transition_curve_linear_out <= 1'b0;
      sync_mode_out <= 1'b0;
      chan_out <= '0;
    end else begin
      chip_active_enable_out <= chip_ctrl_q[LCR_BIT_CHIP_EN];
      undervolt_detect_enable_out <= !undervolt_detect_off;
      overtemp_detect_enable_out <= !overtemp_detect_off;
      undervolt_threshold_10mv_out <= lcr_uv_th_10mv(undervolt_threshold);
      max_current_ma_out <= lcr_imax_ma(max_current_code);
      carrier_hz_out <= carrier_select_a ? LCR_CARRIER_HZ_1 : LCR_CARRIER_HZ_0;
      transition_curve_linear_out <= transition_curve_select;
      sync_mode_out <= sync_sel;
      chan_out <= chan_d;
    end
  end

  always_comb begin
    rdata_d = 8'h00;
    unique case (reg_req_in.addr)
      LCR_OFS_CHIP_CTRL: rdata_d = chip_ctrl_q;
      LCR_OFS_EVT_STATUS: begin
        rdata_d[LCR_BIT_UV_FLAG] = undervolt_status_flag_q;
        rdata_d[LCR_BIT_OT_FLAG] = overtemp_status_flag_q;
      end
      LCR_OFS_PAT_STATUS: rdata_d = 8'({pattern_running});
      LCR_OFS_PROT: rdata_d = prot_q;
      LCR_OFS_LED_CTRL: rdata_d = led_ctrl_q;
      LCR_OFS_CH0_CFG: rdata_d = ch_cfg_q[0];
      LCR_OFS_CH1_CFG: rdata_d = ch_cfg_q[1];
      LCR_OFS_CH2_CFG: rdata_d = ch_cfg_q[2];
      default: rdata_d = 8'h00;
    endcase
  end

  always_ff @(posedge clk_in) begin
    if (rst_in) begin
      reg_rdata_out <= 8'h00;
      reg_rdata_valid_out <= 1'b0;
    end else begin
      reg_rdata_out <= reg_req_in.rd ? rdata_d : 8'h00;
      reg_rdata_valid_out <= reg_req_in.rd;
    end
  end

  property p_pat_status_read;
    @(posedge clk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr == LCR_OFS_PAT_STATUS) |=>
      (reg_rdata_out == {5'h00, $past(pattern_running)}) && reg_rdata_valid_out;
  endproperty
  a_pat_status_read: assert property (p_pat_status_read) else $error("pattern status read wrong");

  property p_uv_shutdown;
    @(posedge clk_in) disable iff (rst_in)
    (undervolt_status_flag_q && !uv_flag_prev_q && !undervolt_protect_off) |=>
      !chip_ctrl_q[LCR_BIT_CHIP_EN] ##1 !chip_active_enable_out;
  endproperty
  a_uv_shutdown: assert property (p_uv_shutdown) else $error("undervolt did not clear chip enable");

  property p_ot_shutdown;
    @(posedge clk_in) disable iff (rst_in)
    (overtemp_status_flag_q && !overtemp_protect_off) |=> !chip_ctrl_q[LCR_BIT_CHIP_EN];
  endproperty
  a_ot_shutdown: assert property (p_ot_shutdown) else $error("overtemp did not clear chip enable");

  property p_uv_detect_off;
    @(posedge clk_in) disable iff (rst_in)
    (undervolt_detect_off && !undervolt_status_flag_q) |=> !undervolt_status_flag_q;
  endproperty
  a_uv_detect_off: assert property (p_uv_detect_off) else $error("undervolt flag set while detection off");

  property p_flag_set_wins;
    @(posedge clk_in) disable iff (rst_in)
    (status_read && uv_sync_q && !undervolt_detect_off) |=> undervolt_status_flag_q;
  endproperty
  a_flag_set_wins: assert property (p_flag_set_wins) else $error("undervolt event lost on clearing read");

  property p_flag_read_clear;
    @(posedge clk_in) disable iff (rst_in)
    (status_read && !ot_set) |=> !overtemp_status_flag_q;
  endproperty
  a_flag_read_clear: assert property (p_flag_read_clear) else $error("overtemp flag not cleared by read");

  property p_uv_threshold;
    @(posedge clk_in) disable iff (rst_in)
    (wr_prot && reg_req_in.wdata[LCR_LSB_UV_TH +: 2] == 2'b11) |=> ##1 (undervolt_threshold_10mv_out == 8'he6);
  endproperty
  a_uv_threshold: assert property (p_uv_threshold) else $error("threshold code 3 is not 2.3 V");

  property p_max_current;
    @(posedge clk_in) disable iff (rst_in)
    (wr_prot && reg_req_in.wdata[LCR_LSB_IMAX +: 2] == 2'b10) |=> ##1 (max_current_ma_out == 5'h05);
  endproperty
  a_max_current: assert property (p_max_current) else $error("max current code 2 is not 5 mA");

  property p_reserved_led_bit;
    @(posedge clk_in) disable iff (rst_in)
    (reg_req_in.rd && reg_req_in.addr == LCR_OFS_LED_CTRL) |=> !reg_rdata_out[LCR_BIT_LED_RSVD];
  endproperty
  a_reserved_led_bit: assert property (p_reserved_led_bit) else $error("reserved LED control bit read as one");

  property p_standby_outputs_off;
    @(posedge clk_in) disable iff (rst_in)
    !chip_ctrl_q[LCR_BIT_CHIP_EN] |=> (chan_out[0].output_enable == 1'b0) && (chan_out[2].output_enable == 1'b0);
  endproperty
  a_standby_outputs_off: assert property (p_standby_outputs_off) else $error("channel on while in standby");

  property p_fade_manual_only;
    @(posedge clk_in) disable iff (rst_in)
    chan_out[1].pattern_mode |-> !chan_out[1].fade_in && !chan_out[1].fade_out;
  endproperty
  a_fade_manual_only: assert property (p_fade_manual_only) else $error("fade active in pattern mode");

  property p_sync_follow;
    @(posedge clk_in) disable iff (rst_in)
    sync_sel |=> chan_out[2].pwm_from_ch0 && (chan_out[2].pattern_mode == $past(ch_cfg_q[0][LCR_BIT_PAT_MODE]));
  endproperty
  a_sync_follow: assert property (p_sync_follow) else $error("channel 2 does not follow channel 0 in sync");

  property p_carrier_select;
    @(posedge clk_in) disable iff (rst_in)
    (wr_led && reg_req_in.wdata[LCR_BIT_CARRIER]) |=> ##1 (carrier_hz_out == 8'h7d);
  endproperty
  a_carrier_select: assert property (p_carrier_select) else $error("carrier bit set is not 125 Hz");

  property p_enable_on;
    @(posedge clk_in) disable iff (rst_in)
    (chip_ctrl_q[LCR_BIT_CHIP_EN] && chx_output_enable[1]) |=> chan_out[1].output_enable;
  endproperty
  a_enable_on: assert property (p_enable_on) else $error("enabled channel 1 stayed off while active");

endmodule // lcr_regs

// File: verif/lcr_host_model.sv
`timescale 1ns/100ps
module lcr_host_model
  import lcr_pkg::*;
(
  input wire logic clk_in,
  input wire logic [7:0] rdata_in,
  input wire logic valid_in,
  output lcr_reg_req_s req_out
);
  initial req_out = '0;
  // at least one idle cycle between requests (two after a read), so wr/rd never overlap
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    if (a == LCR_OFS_LED_CTRL) begin
      d[LCR_BIT_LED_RSVD] = 1'b0;
    end
    @(posedge clk_in) req_out <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clk_in) req_out <= '0;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d, output logic v);
    @(posedge clk_in) req_out <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 8'h00};
    @(posedge clk_in) req_out <= '0;
    @(posedge clk_in);
    d = rdata_in;
    v = valid_in;
  endtask
endmodule // lcr_host_model

// File: verif/lcr_regs_tb.sv
`timescale 1ns/100ps
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin miscompares++; \
  $display("mismatch %s exp %0h got %0h", nm, e, g); end end
module lcr_regs_tb;
  import lcr_pkg::*;
  logic clk_in = 1'b0;
  logic rst_in = 1'b1;
  lcr_reg_req_s req;
  logic [7:0] rdata, th, hz, d;
  logic valid, uv = 1'b0, ot = 1'b0, chip_en, uv_en, ot_en, lin, sync, v;
  logic [2:0] done = 3'b000;
  logic [2:0][3:0] rep = '0;
  logic [4:0] imax;
  lcr_chan_s [2:0] chan;
  int miscompares = 0;
  int n_compared = 0;
  always #2 clk_in = ~clk_in;
  lcr_host_model u_host(.clk_in(clk_in), .rdata_in(rdata), .valid_in(valid), .req_out(req));
  lcr_regs u_dut(.clk_in(clk_in), .rst_in(rst_in), .reg_req_in(req), .reg_rdata_out(rdata),
    .reg_rdata_valid_out(valid), .undervolt_detect_in(uv), .overtemp_detect_in(ot),
    .pattern_cycle_done_in(done), .pattern_repeat_in(rep), .chip_active_enable_out(chip_en),
    .undervolt_detect_enable_out(uv_en), .overtemp_detect_enable_out(ot_en),
    .undervolt_threshold_10mv_out(th), .max_current_ma_out(imax), .carrier_hz_out(hz),
    .transition_curve_linear_out(lin), .sync_mode_out(sync), .chan_out(chan));
  task automatic settle();
    repeat (2) @(posedge clk_in);
    #1;
  endtask
  task automatic complete_run();
    $display("compared %0d mismatches %0d", n_compared, miscompares);
    if (miscompares == 0 && n_compared > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask
  task automatic t_reset();
    logic [7:0] ofs[7] = '{8'h03, 8'h04, 8'h30, 8'h31, 8'h32, 8'h33, 8'h20};
    foreach (ofs[i]) begin
      u_host.rd(ofs[i], d, v);
      `CHK("reset reg", 8'h00, d)
      `CHK("rd valid", 1'b1, v)
    end
    `CHK("thr", 8'hc8, th)
    `CHK("imax", 5'h0f, imax)
    `CHK("carrier", 8'hfa, hz)
    `CHK("chip en", 1'b0, chip_en)
    `CHK("uv det", 1'b1, uv_en)
    $display("test reset done");
  endtask
  task automatic t_prot();
    logic [4:0] im[4] = '{5'h0f, 5'h1e, 5'h05, 5'h0a};
    for (int c = 0; c < 4; c++) begin
      u_host.wr(8'h04, 8'({c[1:0], c[1:0]}));
      settle();
      `CHK("thr", 8'(8'hc8 + 8'h0a * c), th)
      `CHK("imax", im[c], imax)
    end
    u_host.wr(8'h04, 8'h30);
    u_host.wr(8'h30, 8'h28);
    settle();
    `CHK("uv det", 1'b0, uv_en)
    `CHK("ot det", 1'b0, ot_en)
    `CHK("carrier", 8'h7d, hz)
    `CHK("curve", 1'b1, lin)
    u_host.rd(8'h30, d, v);
    `CHK("led ctrl", 8'h28, d)
    $display("test prot done");
  endtask
  task automatic t_chan();
    u_host.wr(8'h04, 8'h00);
    u_host.wr(8'h01, 8'h01);
    u_host.wr(8'h30, 8'h07);
    u_host.wr(8'h31, 8'he3);
    u_host.wr(8'h32, 8'hf5);
    settle();
    `CHK("sync", 1'b1, sync)
    `CHK("follow", 2'b10, {chan[1].pwm_from_ch0, chan[0].pwm_from_ch0})
    `CHK("fades", 2'b11, {chan[1].fade_in, chan[1].fade_out})
    `CHK("mode", 1'b0, chan[1].pattern_mode)
    `CHK("scale", 4'h5, chan[1].current_scale)
    `CHK("cur", 9'h04b, chan[1].current_x15)
    `CHK("cur0", 9'h02d, chan[0].current_x15)
    `CHK("oe", 1'b1, chan[1].output_enable)
    u_host.rd(8'h32, d, v);
    `CHK("cfg1", 8'h75, d)
    u_host.wr(8'h31, 8'h00);
    settle();
    `CHK("own mode", 2'b10, {chan[1].pattern_mode, chan[1].fade_in})
    $display("test chan done");
  endtask
  task automatic t_trip();
    for (int k = 0; k < 2; k++) begin
      for (int off = 0; off < 2; off++) begin
        u_host.wr(8'h04, off ? (k ? 8'h40 : 8'h80) : 8'h00);
        u_host.wr(8'h01, 8'h01);
        if (k) ot <= 1'b1;
        else uv <= 1'b1;
        repeat (8) @(posedge clk_in);
        #1;
        `CHK("trip", off[0], chip_en)
        uv <= 1'b0;
        ot <= 1'b0;
        settle();
        u_host.rd(8'h02, d, v);
        `CHK("flag", k ? 8'h04 : 8'h08, d)
        u_host.rd(8'h02, d, v);
        `CHK("flag clr", 8'h00, d)
      end
    end
    $display("test trip done");
  endtask
  task automatic t_pat();
    rep[0] <= 4'h2;
    u_host.wr(8'h01, 8'h01);
    u_host.wr(8'h31, 8'h10);
    // channel 1 is left in pattern mode by the channel test; park it in manual mode
    u_host.wr(8'h32, 8'h00);
    u_host.wr(8'h33, 8'h10);
    settle();
    u_host.rd(8'h03, d, v);
    `CHK("pat run", 8'h05, d)
    repeat (2) begin
      @(posedge clk_in) done <= 3'b001;
      @(posedge clk_in) done <= 3'b000;
    end
    settle();
    u_host.rd(8'h03, d, v);
    `CHK("pat done", 8'h04, d)
    u_host.wr(8'h30, 8'h03);
    settle();
    u_host.rd(8'h03, d, v);
    `CHK("pat off", 8'h00, d)
    $display("test pattern done");
  endtask
  initial begin
    #200000;
    miscompares++;
    complete_run();
  end
  initial begin
    repeat (12) @(posedge clk_in);
    rst_in <= 1'b0;
    @(posedge clk_in);
    t_reset();
    t_prot();
    t_chan();
    t_trip();
    t_pat();
    complete_run();
  end
endmodule // lcr_regs_tb
